/* rse_pkg.sv */
// Constants, field layouts and carriers for the rotate/subtract/sleep unit.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package rse_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned FILE_DEPTH = 8;
	localparam int unsigned FILE_IDX_W = 3;

	// Register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ACC = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_WDOG = 8'h0c;
	localparam logic [2:0] OFF_FILE_HI = 3'h1;

	// Command word fields
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_DEST_BIT = 2;
	localparam int unsigned CMD_FADDR_LSB = 8;
	localparam int unsigned CMD_LIT_LSB = 16;

	// Operation codes
	localparam logic [1:0] OP_ROT_LEFT = 2'h0;
	localparam logic [1:0] OP_ROT_RIGHT = 2'h1;
	localparam logic [1:0] OP_LIT_MINUS_ACC = 2'h2;
	localparam logic [1:0] OP_POWER_DOWN = 2'h3;

	// Status register layout: flags in bits 4:0, sleep indicator here
	localparam int unsigned STATUS_SLEEP_BIT = 8;

	// Reset values and the prescaler's last count
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] FILE_RESET = 8'h00;
	localparam logic [7:0] WDOG_CLEAR = 8'h00;
	localparam logic [7:0] PRESC_CLEAR = 8'h00;
	localparam logic [7:0] PRESC_LAST = 8'hff;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic timeout_flag;
		logic power_down_flag;
		logic zero;
		logic half_carry_flag;
		logic carry;
	} rse_status_s;

	localparam rse_status_s STATUS_RESET = 5'h18;

	typedef struct packed {
		logic [7:0] literal;
		logic [FILE_IDX_W-1:0] faddr;
		logic dest;
		logic [1:0] op;
	} rse_cmd_s;

endpackage

/* rse_exec.sv */
// Execution unit: rotate through carry, literal minus accumulator, power-down.
// Assumes one clock, a synchronous active-low reset and an AXI4-Lite master.
//
// Overview of operation
// - Rotate left moves the file register toward bit 7, old carry into bit 0, old bit 7 into carry.
// - Rotate left writes the accumulator when dest is 0 and the file register when dest is 1.
// - Rotate right moves the file register toward bit 0, old carry into bit 7, old bit 0 into carry.
// - Rotate right writes the accumulator when dest is 0 and the file register when dest is 1.
// - Power-down clears the power-down flag and sets the timeout flag.
// - Power-down clears the watchdog counter and its prescaler.
// - After power-down the unit sleeps with its clock stopped and runs no command until wake-up.
// - Literal minus accumulator is computed in two's complement and written to the accumulator.
// - Carry clears when acc exceeds literal, half carry clears when acc low nibble exceeds literal's.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module rse_exec
	import rse_pkg::*;
(
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Wake-up pin and oscillator state
	input wire logic wake_pin,
	output logic osc_stopped
);

	////////////////////////////////////////////////////////////////////////
	// State

	logic aw_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic w_full_q;
	logic [DATA_W-1:0] w_data_q;
	logic w_lane0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic [7:0] acc_q;
	logic [7:0] file_q [FILE_DEPTH];
	rse_status_s status_q;
	logic [7:0] wdog_q;
	logic [7:0] presc_q;
	logic sleep_q;
	logic [DATA_W-1:0] cmd_q;
	logic wake_s1_q;
	logic wake_s2_q;
	logic wake_s3_q;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire logic do_wr = ce & aw_full_q & w_full_q & ~bvalid_q;
	wire logic do_rd = ce & s_axi_arvalid & ~rvalid_q;
	wire logic wr_cmd = aw_addr_q == OFF_CMD;
	wire logic wr_acc = aw_addr_q == OFF_ACC;
	wire logic wr_stat = aw_addr_q == OFF_STATUS;
	wire logic wr_wdog = aw_addr_q == OFF_WDOG;
	wire logic wr_file = aw_addr_q[7:5] == OFF_FILE_HI;
	wire logic wr_hit = wr_cmd | wr_acc | wr_stat | wr_wdog | wr_file;
	wire logic [FILE_IDX_W-1:0] wr_idx = aw_addr_q[4:2];
	wire logic [FILE_IDX_W-1:0] rd_idx = s_axi_araddr[4:2];

	assign s_axi_awready = ce & ~aw_full_q;
	assign s_axi_wready = ce & ~w_full_q;
	assign s_axi_arready = ce & ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign osc_stopped = sleep_q;

	////////////////////////////////////////////////////////////////////////
	// Datapath

	// Commands are ignored while asleep: the core clock is stopped
	wire logic exec = do_wr & wr_cmd & ~sleep_q;
	wire rse_cmd_s cmd = '{literal: w_data_q[CMD_LIT_LSB +: 8],
		faddr: w_data_q[CMD_FADDR_LSB +: FILE_IDX_W],
		dest: w_data_q[CMD_DEST_BIT],
		op: w_data_q[CMD_OP_LSB +: 2]};
	wire logic [7:0] fval = file_q[cmd.faddr];
	wire logic [7:0] rot_l = {fval[6:0], status_q.carry};
	wire logic [7:0] rot_r = {status_q.carry, fval[7:1]};
	wire logic [7:0] diff = cmd.literal - acc_q;
	wire logic sub_c = acc_q <= cmd.literal;
	wire logic sub_dc = acc_q[3:0] <= cmd.literal[3:0];
	wire logic sub_z = diff == 8'h00;
	wire logic is_rl = exec & (cmd.op == OP_ROT_LEFT);
	wire logic is_rr = exec & (cmd.op == OP_ROT_RIGHT);
	wire logic is_sub = exec & (cmd.op == OP_LIT_MINUS_ACC);
	wire logic is_pd = exec & (cmd.op == OP_POWER_DOWN);
	wire logic is_rot = is_rl | is_rr;
	wire logic [7:0] rot_res = is_rl ? rot_l : rot_r;
	wire logic rot_c = is_rl ? fval[7] : fval[0];
	wire logic acc_from_op = (is_rot & ~cmd.dest) | is_sub;
	wire logic file_from_op = is_rot & cmd.dest;
	wire logic [7:0] acc_op_val = is_sub ? diff : rot_res;
	wire logic wr_lane = do_wr & w_lane0_q;
	wire logic wake = wake_s2_q & wake_s3_q;

	////////////////////////////////////////////////////////////////////////
	// Read mux

	wire logic rd_file = s_axi_araddr[7:5] == OFF_FILE_HI;
	wire logic rd_hit = rd_file | (s_axi_araddr == OFF_CMD) | (s_axi_araddr == OFF_ACC) |
		(s_axi_araddr == OFF_STATUS) | (s_axi_araddr == OFF_WDOG);
	wire logic [DATA_W-1:0] rd_status = {23'h000000, sleep_q, 3'h0, status_q};
	wire logic [DATA_W-1:0] rd_val =
		rd_file ? {24'h000000, file_q[rd_idx]} :
		(s_axi_araddr == OFF_CMD) ? cmd_q :
		(s_axi_araddr == OFF_ACC) ? {24'h000000, acc_q} :
		(s_axi_araddr == OFF_STATUS) ? rd_status :
		(s_axi_araddr == OFF_WDOG) ? {16'h0000, presc_q, wdog_q} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// Bus channels

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_lane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_lane0_q <= s_axi_wstrb[0];
			end else if (do_wr) begin
				w_full_q <= 1'b0;
			end
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (do_rd) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_val;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Accumulator, file registers, command echo

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= ACC_RESET;
			cmd_q <= 32'h00000000;
		end else if (ce) begin
			if (acc_from_op) begin
				acc_q <= acc_op_val;
			end else if (wr_lane && wr_acc) begin
				acc_q <= w_data_q[7:0];
			end
			if (exec) begin
				cmd_q <= w_data_q;
			end
		end
	end

	for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				file_q[i] <= FILE_RESET;
			end else if (ce) begin
				if (file_from_op && cmd.faddr == FILE_IDX_W'(i)) begin
					file_q[i] <= rot_res;
				end else if (wr_lane && wr_file && wr_idx == FILE_IDX_W'(i)) begin
					file_q[i] <= w_data_q[7:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= STATUS_RESET;
		end else if (ce) begin
			if (is_rot) begin
				status_q.carry <= rot_c;
			end else if (is_sub) begin
				status_q.carry <= sub_c;
				status_q.half_carry_flag <= sub_dc;
				status_q.zero <= sub_z;
			end else if (is_pd) begin
				status_q.power_down_flag <= 1'b0;
				status_q.timeout_flag <= 1'b1;
			end else if (wr_lane && wr_stat) begin
				status_q <= w_data_q[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog count, sleep and wake

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdog_q <= WDOG_CLEAR;
			presc_q <= PRESC_CLEAR;
			sleep_q <= 1'b0;
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
			wake_s3_q <= 1'b0;
		end else if (ce) begin
			wake_s1_q <= wake_pin;
			wake_s2_q <= wake_s1_q;
			wake_s3_q <= wake_s2_q;
			if (is_pd) begin
				wdog_q <= WDOG_CLEAR;
				presc_q <= PRESC_CLEAR;
				sleep_q <= 1'b1;
			end else if (sleep_q) begin
				// Counters hold: their clock is the stopped oscillator
				sleep_q <= ~wake;
			end else begin
				presc_q <= presc_q + 8'h01;
				if (presc_q == PRESC_LAST) begin
					wdog_q <= wdog_q + 8'h01;
				end
			end
		end
	end

endmodule

`default_nettype wire

/* rse_exec_properties.sv */
// Port properties of the execution unit.
// Assumes a bind to rse_exec on its own clock and reset.
`timescale 1ns/1ps
`default_nettype none
module rse_exec_properties (
	// Clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sleep
	input wire logic wake_pin,
	input wire logic osc_stopped
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	// Pin low long enough to flush the synchroniser
	sequence quiet_sleep;
		(osc_stopped && !wake_pin && ce)[*4];
	endsequence
	write_answer_a: assert property (wr_taken ##1 ce |=> s_axi_bvalid)
		else $error("write response late");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	ce_freeze_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while frozen");
	sleep_hold_a: assert property (quiet_sleep |=> osc_stopped)
		else $error("left sleep without wake");
	wake_exit_a: assert property ((wake_pin && ce)[*6] |-> !osc_stopped)
		else $error("no wake");
endmodule
bind rse_exec rse_exec_properties u_props (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .wake_pin, .osc_stopped);
`default_nettype wire

/* rse_wake_src.sv */
// Wake-up source standing in for the external wake pin.
// Assumes the bench raises go for a wake and drops it afterwards.
`timescale 1ns/1ps
`default_nettype none
module rse_wake_src (
	// Clock and request
	input wire logic aclk,
	input wire logic go,
	// Level to the unit
	output logic wake_pin
);
	// Starts low so the unit never sees an unknown pin
	logic [2:0] dly_q = 3'h0;
	always @(posedge aclk) dly_q <= {dly_q[1:0], go};
	assign wake_pin = dly_q[2];
endmodule
`default_nettype wire

/* rse_exec_tb.sv */
// Bench for the execution unit: random ops, bus errors, sleep and wake.
// Assumes rse_exec, its bound checker and the wake source.
`timescale 1ns/1ps
`default_nettype none
module rse_exec_tb
	import rse_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, go = 1'b0, wake_pin, osc_stopped;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, av, fv, lit, res, xa;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h484c;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dest;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, op, exp_b[$];
	logic [33:0] exp_r[$];
	logic [4:0] st, xs;
	logic [2:0] idx;
	int fails = 0, comparisons = 0, cyc = 0;
	rse_exec dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .wake_pin, .osc_stopped);
	rse_wake_src u_wake (.aclk, .go, .wake_pin);
	always #2.5 aclk = ~aclk;
	// Periodic freeze to stretch the handshakes that it overlaps
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		ce <= !aresetn || (cyc % 7 != 6);
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Bus master; a response only counts on an enabled edge, since the frozen slave keeps it up
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		exp_b.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (s_axi_awready) aw_p = 1'b0;
			if (s_axi_wready) w_p = 1'b0;
			s_axi_awvalid <= aw_p;
			s_axi_wvalid <= w_p;
		end
		do @(posedge aclk); while (!(s_axi_bvalid && ce));
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_r.push_back({r, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!(s_axi_rvalid && ce));
		s_axi_rready <= 1'b0;
	endtask
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready && ce)
			chk("bresp", {32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
		if (s_axi_rvalid && s_axi_rready && ce)
			chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_STATUS, {27'h0, STATUS_RESET}, RESP_OKAY);
		wr(8'h40, seed, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			{lit, av, fv} = seed[23:0];
			seed = lfsr(seed);
			{st, idx, dest, op} = seed[10:0];
			if (op == OP_POWER_DOWN || i < 2) op = OP_LIT_MINUS_ACC;
			if (i == 0) lit = av;
			if (i == 1) av = lit + 8'h01;
			xs = st;
			case (op)
				OP_ROT_LEFT: {xs[0], res} = {fv, st[0]};
				OP_ROT_RIGHT: {res, xs[0]} = {st[0], fv};
				default: begin
					res = lit - av;
					xs[2:0] = {res == 8'h00, av[3:0] <= lit[3:0], av <= lit};
				end
			endcase
			xa = (op == OP_LIT_MINUS_ACC || !dest) ? res : av;
			wr({OFF_FILE_HI, idx, 2'b00}, {24'h0, fv}, RESP_OKAY);
			wr(OFF_ACC, {24'h0, av}, RESP_OKAY);
			wr(OFF_STATUS, {27'h0, st}, RESP_OKAY);
			wr(OFF_CMD, {8'h00, lit, 5'h00, idx, 5'h00, dest, op}, RESP_OKAY);
			rd(OFF_ACC, {24'h0, xa}, RESP_OKAY);
			rd({OFF_FILE_HI, idx, 2'b00}, {24'h0, (op != OP_LIT_MINUS_ACC && dest) ? res : fv}, RESP_OKAY);
			rd(OFF_STATUS, {27'h0, xs}, RESP_OKAY);
		end
		wr(OFF_CMD, {30'h0, OP_POWER_DOWN}, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk("osc_stopped", {33'h0, osc_stopped}, 34'h1);
		rd(OFF_STATUS, {23'h0, 1'b1, 3'h0, 2'b10, xs[2:0]}, RESP_OKAY);
		rd(OFF_WDOG, 32'h0, RESP_OKAY);
		wr(OFF_CMD, 32'h0, RESP_OKAY);
		rd(OFF_ACC, {24'h0, xa}, RESP_OKAY);
		go <= 1'b1;
		while (osc_stopped !== 1'b0) @(negedge aclk);
		@(posedge aclk);
		go <= 1'b0;
		wr(OFF_CMD, {16'h0, 16'h0002}, RESP_OKAY);
		rd(OFF_ACC, {24'h0, 8'h00 - xa}, RESP_OKAY);
		tally_and_finish();
	end
endmodule
`default_nettype wire
